// file: logic/commit_por_xo_cap_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - A 4-bit read-write page field chooses the region the commit operation fills.
// - Six pages exist; two strap pins select the startup page at power-up.
// - Slow power-on enables sit at bit 2 (PLL A) and bit 6 (PLL B).
// - Slow bit with matching loop-bandwidth bit inserts about 60 ms power-on delay.
// - Crystal load-cap code reads back as 10 bits split over two registers.
module commit_por_xo_cap_regs #(
  parameter int unsigned SLOW_DELAY_CYCLES = commit_por_xo_cap_pkg::SLOW_DELAY_CYC
) (
  input  wire logic                                     sys_clk,
  input  wire logic                                     rstn,
  input  wire logic [commit_por_xo_cap_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [commit_por_xo_cap_pkg::DATA_W-1:0] regWdata,
  input  wire logic                                     regWrite,
  input  wire logic                                     regRead,
  output logic      [commit_por_xo_cap_pkg::DATA_W-1:0] regRdata,
  input  wire logic [commit_por_xo_cap_pkg::STRAP_W-1:0] pageStrap,
  input  wire logic [commit_por_xo_cap_pkg::CAP_W-1:0]  crystalLoadCapIn,
  input  wire logic                                     pll_a_loop_bandwidth,
  input  wire logic                                     pll_b_loop_bandwidth,
  input  wire logic                                     supplyGood,
  output logic      [commit_por_xo_cap_pkg::PAGE_W-1:0] commit_page_field,
  output logic      [commit_por_xo_cap_pkg::PAGE_W-1:0] startupPage,
  output logic                                          pll_a_slow_power_on,
  output logic                                          pll_b_slow_power_on,
  output logic                                          powerOnDone
);

  logic [commit_por_xo_cap_pkg::PAGE_W-1:0]  page_r;
  logic [commit_por_xo_cap_pkg::PAGE_W-1:0]  page_nxt;
  logic                                      slowA_r;
  logic                                      slowA_nxt;
  logic                                      slowB_r;
  logic                                      slowB_nxt;
  logic [commit_por_xo_cap_pkg::CAP_W-1:0]   cap_r;
  logic [commit_por_xo_cap_pkg::CAP_W-1:0]   cap_nxt;
  logic [commit_por_xo_cap_pkg::DATA_W-1:0]  rdata_r;
  logic [commit_por_xo_cap_pkg::DATA_W-1:0]  rdata_nxt;
  logic [commit_por_xo_cap_pkg::PAGE_W-1:0]  startPage_r;
  logic [commit_por_xo_cap_pkg::PAGE_W-1:0]  startPage_nxt;
  logic                                      strapTaken_r;
  logic                                      strapTaken_nxt;
  commit_por_xo_cap_pkg::por_state_type      porState_r;
  commit_por_xo_cap_pkg::por_state_type      porState_nxt;
  logic                                      done_r;
  logic                                      done_nxt;
  logic                                      delayLoad;
  logic                                      delayExpired;
  logic                                      slowNeeded;

  localparam logic [commit_por_xo_cap_pkg::DELAY_CNT_W-1:0] DELAY_LOAD =
    commit_por_xo_cap_pkg::DELAY_CNT_W'(SLOW_DELAY_CYCLES);

  // Register writes and read data. Reserved bits are never stored, so they read zero.
  always_comb begin
    page_nxt  = page_r;
    slowA_nxt = slowA_r;
    slowB_nxt = slowB_r;
    rdata_nxt = rdata_r;
    // Writes to the read-only capacitance registers and to unmapped addresses fall through.
    // Code values above five are stored as written; the commit logic decides their fate.
    if (regWrite && (regAddr == commit_por_xo_cap_pkg::COMMIT_PAGE_SELECT_ADDR)) begin
      page_nxt = regWdata[commit_por_xo_cap_pkg::PAGE_LSB +: commit_por_xo_cap_pkg::PAGE_W];
    end
    if (regWrite && (regAddr == commit_por_xo_cap_pkg::POWER_ON_RAMP_CONTROL_ADDR)) begin
      slowA_nxt = regWdata[commit_por_xo_cap_pkg::PLL_A_SLOW_BIT];
      slowB_nxt = regWdata[commit_por_xo_cap_pkg::PLL_B_SLOW_BIT];
    end
    // A read and a write in one cycle return the old value, since reads use the stored copy.
    if (regRead) begin
      rdata_nxt = commit_por_xo_cap_pkg::ZERO_BYTE;
      unique case (regAddr)
        commit_por_xo_cap_pkg::COMMIT_PAGE_SELECT_ADDR: begin
          rdata_nxt[commit_por_xo_cap_pkg::PAGE_LSB +: commit_por_xo_cap_pkg::PAGE_W] = page_r;
        end
        commit_por_xo_cap_pkg::POWER_ON_RAMP_CONTROL_ADDR: begin
          rdata_nxt[commit_por_xo_cap_pkg::PLL_A_SLOW_BIT] = slowA_r;
          rdata_nxt[commit_por_xo_cap_pkg::PLL_B_SLOW_BIT] = slowB_r;
        end
        commit_por_xo_cap_pkg::CRYSTAL_LOAD_CAP_HIGH_ADDR: begin
          rdata_nxt[commit_por_xo_cap_pkg::CAP_HIGH_W-1:0] =
            cap_r[commit_por_xo_cap_pkg::CAP_W-1:commit_por_xo_cap_pkg::CAP_LOW_W];
        end
        commit_por_xo_cap_pkg::CRYSTAL_LOAD_CAP_LOW_ADDR: begin
          rdata_nxt = cap_r[commit_por_xo_cap_pkg::CAP_LOW_W-1:0];
        end
        default: begin
          rdata_nxt = commit_por_xo_cap_pkg::ZERO_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      page_r  <= commit_por_xo_cap_pkg::PAGE_RESET;
      slowA_r <= commit_por_xo_cap_pkg::SLOW_RESET;
      slowB_r <= commit_por_xo_cap_pkg::SLOW_RESET;
      rdata_r <= commit_por_xo_cap_pkg::ZERO_BYTE;
    end else begin
      page_r  <= page_nxt;
      slowA_r <= slowA_nxt;
      slowB_r <= slowB_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // The capacitance code is sampled every cycle so both halves track the live selection.
  // The halves are read in separate accesses, so a code that moves between them can read
  // back torn; software that needs a consistent pair should read twice and compare.
  always_comb begin
    cap_nxt = crystalLoadCapIn;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cap_r <= commit_por_xo_cap_pkg::CAP_RESET;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  // Startup page is latched once after reset release; later strap changes are ignored.
  // Two strap pins reach pages zero to three only; the remaining pages are reached
  // through software alone.
  always_comb begin
    startPage_nxt  = startPage_r;
    strapTaken_nxt = strapTaken_r;
    if (!strapTaken_r) begin
      startPage_nxt  = {{(commit_por_xo_cap_pkg::PAGE_W-commit_por_xo_cap_pkg::STRAP_W){1'b0}},
                        pageStrap};
      strapTaken_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      startPage_r  <= commit_por_xo_cap_pkg::PAGE_RESET;
      strapTaken_r <= 1'b0;
    end else begin
      startPage_r  <= startPage_nxt;
      strapTaken_r <= strapTaken_nxt;
    end
  end

  // Power-on sequencing: the long wait applies only when a slow bit meets its bandwidth bit.
  assign slowNeeded = (slowA_r && pll_a_loop_bandwidth) || (slowB_r && pll_b_loop_bandwidth);

  always_comb begin
    porState_nxt = porState_r;
    done_nxt     = done_r;
    delayLoad    = 1'b0;
    unique case (porState_r)
      commit_por_xo_cap_pkg::POR_IDLE: begin
        done_nxt = 1'b0;
        if (supplyGood) begin
          if (slowNeeded) begin
            delayLoad    = 1'b1;
            porState_nxt = commit_por_xo_cap_pkg::POR_WAIT;
          end else begin
            done_nxt     = 1'b1;
            porState_nxt = commit_por_xo_cap_pkg::POR_DONE;
          end
        end
      end
      commit_por_xo_cap_pkg::POR_WAIT: begin
        // A supply drop abandons the wait. The full delay then runs again on the next
        // ramp, which costs time but never shortens the guard.
        if (!supplyGood) begin
          porState_nxt = commit_por_xo_cap_pkg::POR_IDLE;
        end else if (delayExpired) begin
          done_nxt     = 1'b1;
          porState_nxt = commit_por_xo_cap_pkg::POR_DONE;
        end
      end
      commit_por_xo_cap_pkg::POR_DONE: begin
        // Done stays up until the supply drops; a new ramp runs the whole sequence again.
        if (!supplyGood) begin
          done_nxt     = 1'b0;
          porState_nxt = commit_por_xo_cap_pkg::POR_IDLE;
        end
      end
      default: begin
        done_nxt     = 1'b0;
        porState_nxt = commit_por_xo_cap_pkg::POR_IDLE;
      end
    endcase
  end

  // The counter is reloaded on every entry to the wait, so an abandoned wait leaves
  // no residue that could shorten the next one.
  por_delay_counter #(
    .WIDTH (commit_por_xo_cap_pkg::DELAY_CNT_W)
  ) u_delay (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .load      (delayLoad),
    .loadValue (DELAY_LOAD),
    .expired   (delayExpired)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      porState_r <= commit_por_xo_cap_pkg::POR_IDLE;
      done_r     <= 1'b0;
    end else begin
      porState_r <= porState_nxt;
      done_r     <= done_nxt;
    end
  end

  assign regRdata            = rdata_r;
  assign commit_page_field   = page_r;
  assign startupPage         = startPage_r;
  assign pll_a_slow_power_on = slowA_r;
  assign pll_b_slow_power_on = slowB_r;
  assign powerOnDone         = done_r;

endmodule // commit_por_xo_cap_regs

// file: logic/commit_por_xo_cap_pkg.sv
package commit_por_xo_cap_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] COMMIT_PAGE_SELECT_ADDR     = 8'h91;
  localparam logic [7:0] POWER_ON_RAMP_CONTROL_ADDR  = 8'hAD;
  localparam logic [7:0] CRYSTAL_LOAD_CAP_HIGH_ADDR  = 8'hC7;
  localparam logic [7:0] CRYSTAL_LOAD_CAP_LOW_ADDR   = 8'hC8;

  localparam int unsigned PAGE_W          = 4;
  localparam int unsigned PAGE_LSB        = 0;
  localparam logic [3:0]  PAGE_RESET      = 4'h0;
  localparam logic [3:0]  PAGE_LAST       = 4'h5;
  localparam int unsigned PAGE_COUNT      = 6;
  localparam int unsigned STRAP_W         = 2;

  localparam int unsigned PLL_A_SLOW_BIT  = 2;
  localparam int unsigned PLL_B_SLOW_BIT  = 6;
  localparam logic        SLOW_RESET      = 1'b0;

  localparam int unsigned CAP_W           = 10;
  localparam int unsigned CAP_HIGH_W      = 2;
  localparam int unsigned CAP_LOW_W       = 8;
  localparam logic [9:0]  CAP_RESET       = 10'h000;

  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // Slow power-on delay, nominal figure in milliseconds, and cycle count at 10 MHz.
  localparam int unsigned SLOW_DELAY_MS   = 60;
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned SLOW_DELAY_CYC  = SLOW_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_CNT_W     = 24;

  typedef enum logic [1:0] {
    POR_IDLE = 2'b00,
    POR_WAIT = 2'b01,
    POR_DONE = 2'b10
  } por_state_type;

endpackage

// file: logic/por_delay_counter.sv
`timescale 1ns/1ps
// Counts down a load value and flags when it has reached zero.
module por_delay_counter #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] loadValue,
  output logic                  expired
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (load) begin
      count_nxt = loadValue;
    end else if (count_r != '0) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign expired = (count_r == '0);

endmodule // por_delay_counter

// file: dv/commit_por_xo_cap_properties.sv
`timescale 1ns/1ps
module commit_por_xo_cap_properties #(
  parameter int unsigned SLOW_DELAY_CYCLES = 20
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata,
  input wire logic [1:0] pageStrap,
  input wire logic [9:0] crystalLoadCapIn,
  input wire logic       pll_a_loop_bandwidth,
  input wire logic       pll_b_loop_bandwidth,
  input wire logic       supplyGood,
  input wire logic [3:0] commit_page_field,
  input wire logic [3:0] startupPage,
  input wire logic       pll_a_slow_power_on,
  input wire logic       pll_b_slow_power_on,
  input wire logic       powerOnDone
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Cycles spent waiting for the power-on sequence, and whether a slow request was seen.
  logic [31:0] waitCnt_r;
  logic [31:0] waitCnt_nxt;
  logic        slowSeen_r;
  logic        slowSeen_nxt;
  logic        slowCond;
  assign slowCond = (pll_a_slow_power_on & pll_a_loop_bandwidth)
                  | (pll_b_slow_power_on & pll_b_loop_bandwidth);
  always_comb begin
    waitCnt_nxt = (supplyGood && !powerOnDone) ? waitCnt_r + 32'h1 : 32'h0;
    slowSeen_nxt = supplyGood && (slowSeen_r || (slowCond && !powerOnDone));
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt_r <= 32'h0;
      slowSeen_r <= 1'b0;
    end else begin
      waitCnt_r <= waitCnt_nxt;
      slowSeen_r <= slowSeen_nxt;
    end
  end
  page_write_a: assert property (regWrite && regAddr == 8'h91 |=>
    commit_page_field == $past(regWdata[3:0])) else $error("page write lost");
  page_read_a: assert property (regRead && regAddr == 8'h91 |=>
    regRdata == {4'h0, $past(commit_page_field)}) else $error("page readback wrong");
  slow_write_a: assert property (regWrite && regAddr == 8'hAD |=>
    {pll_b_slow_power_on, pll_a_slow_power_on} == {$past(regWdata[6]), $past(regWdata[2])})
    else $error("slow bits not stored");
  slow_read_a: assert property (regRead && regAddr == 8'hAD |=> regRdata ==
    {1'b0, $past(pll_b_slow_power_on), 3'h0, $past(pll_a_slow_power_on), 2'h0})
    else $error("slow readback wrong");
  cap_high_a: assert property (regRead && regAddr == 8'hC7 && $stable(crystalLoadCapIn)
    |=> regRdata == {6'h00, $past(crystalLoadCapIn[9:8])}) else $error("cap high wrong");
  cap_low_a: assert property (regRead && regAddr == 8'hC8 && $stable(crystalLoadCapIn)
    |=> regRdata == $past(crystalLoadCapIn[7:0])) else $error("cap low wrong");
  startup_page_a: assert property (rstn && !$past(rstn) |=>
    startupPage == {2'h0, $past(pageStrap)}) else $error("startup page wrong");
  quick_done_a: assert property ($rose(powerOnDone) && !slowSeen_r |->
    waitCnt_r == 32'h1) else $error("fast power-on timing wrong");
  slow_done_a: assert property ($rose(powerOnDone) && slowSeen_r |->
    waitCnt_r >= SLOW_DELAY_CYCLES) else $error("slow power-on too short");
  wait_bound_a: assert property (waitCnt_r <= SLOW_DELAY_CYCLES + 3)
    else $error("power-on never completes");
  supply_drop_a: assert property (!supplyGood |=> !powerOnDone)
    else $error("done held without supply");
endmodule // commit_por_xo_cap_properties

bind commit_por_xo_cap_regs commit_por_xo_cap_properties #(
  .SLOW_DELAY_CYCLES(SLOW_DELAY_CYCLES)
) chk (.*);

// file: dv/commit_por_xo_cap_regs_tb.sv
`timescale 1ns/1ps
module commit_por_xo_cap_regs_tb;
  localparam int unsigned N = 20;
  logic        sys_clk, rstn, regWrite, regRead, supplyGood, powerOnDone;
  logic        pll_a_loop_bandwidth, pll_b_loop_bandwidth;
  logic        pll_a_slow_power_on, pll_b_slow_power_on;
  logic [7:0]  regAddr, regWdata, regRdata, d;
  logic [1:0]  pageStrap, strap;
  logic [9:0]  crystalLoadCapIn, cap;
  logic [3:0]  commit_page_field, startupPage;
  logic [15:0] expQ[$];
  logic        rdDly = 1'b0;
  int          nFail, totalChecks, cnt;
  commit_por_xo_cap_regs #(.SLOW_DELAY_CYCLES(N)) dut (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  // Strobes stay up across back-to-back calls; idle drops them.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    {regWrite, regRead, regAddr, regWdata} = {2'h2, a, v};
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {regWrite, regRead, regAddr} = {2'h1, a};
    expQ.push_back({8'h00, e});
    tick();
  endtask
  task automatic idle;
    {regWrite, regRead} = 2'h0;
    tick();
  endtask
  // Read data is registered, so it is judged at the falling edge after the read.
  always @(posedge sys_clk) rdDly <= regRead;
  always @(negedge sys_clk) begin
    if (rdDly === 1'b1) begin
      check("regRdata", regRdata, expQ.pop_front());
    end
  end
  initial begin
    #(3000 * 100);
    nFail++;
    giveVerdict();
  end
  initial begin
    cnt = $urandom(420);
    {regAddr, regWdata, regWrite, regRead, supplyGood} = 19'h00000;
    {pll_a_loop_bandwidth, pll_b_loop_bandwidth, rstn} = 3'h0;
    strap = 2'($urandom());
    pageStrap = strap;
    crystalLoadCapIn = 10'h000;
    repeat (10) tick();
    rstn = 1'b1;
    tick();
    pageStrap = ~strap;
    tick();
    check("startupPage", startupPage, {14'h0000, strap});
    rd(8'h91, 8'h00);
    rd(8'hAD, 8'h00);
    rd(8'h3C, 8'h00);
    for (int p = 0; p < 6; p++) begin
      wr(8'h91, {4'($urandom()), 4'(p)});
      rd(8'h91, 8'(p));
    end
    idle();
    check("commit_page_field", commit_page_field, 16'h0005);
    d = 8'($urandom());
    wr(8'hAD, d);
    wr(8'hC7, 8'hFF);
    wr(8'hC8, 8'hFF);
    rd(8'hAD, d & 8'h44);
    idle();
    check("slowBits", {pll_b_slow_power_on, pll_a_slow_power_on}, {d[6], d[2]});
    repeat (4) begin
      cap = 10'($urandom());
      crystalLoadCapIn = cap;
      idle();
      idle();
      rd(8'hC7, {6'h00, cap[9:8]});
      rd(8'hC8, cap[7:0]);
    end
    wr(8'hAD, 8'h00);
    for (int k = 0; k < 3; k++) begin
      idle();
      supplyGood = 1'b1;
      cnt = 0;
      while (powerOnDone !== 1'b1 && cnt < N + 10) begin
        tick();
        cnt++;
      end
      check("doneDelay", 16'(k ? (cnt >= N && cnt <= N + 3) : cnt == 1), 16'h0001);
      supplyGood = 1'b0;
      tick();
      check("doneDrop", powerOnDone, 16'h0000);
      wr(8'hAD, k ? 8'h40 : 8'h04);
      {pll_a_loop_bandwidth, pll_b_loop_bandwidth} = 2'h3;
    end
    idle();
    giveVerdict();
  end
endmodule // commit_por_xo_cap_regs_tb
